/* design/hcd_detector.sv */
// count and direction logic behind two sense plates, with chopped comparators
// assumes sense values are digitised elsewhere and may change asynchronously
`include "hcd_map.svh"
module hcd_detector #(
    parameter int OSC_CYCLES = `HCD_OSC_CYCLES,
    parameter bit DIR_HIGH_FIRST_LEADS = 1'b1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // digitised sensed values
    input wire hcd_pkg::hcd_sense_s sense_i,
    // switching thresholds, on above off
    input wire logic signed [`HCD_SENSE_W-1:0] th_on_i,
    input wire logic signed [`HCD_SENSE_W-1:0] th_off_i,
    // open-drain outputs, enable high pulls the pin low
    output logic count_o,
    output logic count_oe_o,
    output logic dir_o,
    output logic dir_oe_o
);
    localparam int HALF = (OSC_CYCLES / 2 < 1) ? 1 : OSC_CYCLES / 2;
    localparam int CW = $clog2(OSC_CYCLES + 1);

    hcd_pkg::hcd_sense_s sync1_ff, sync2_ff;
    hcd_pkg::hcd_sense_s held_ff;
    hcd_pkg::hcd_cmp_s cmp_ff, prev_ff;
    hcd_pkg::hcd_phase_e phase_ff;
    logic [CW-1:0] cnt_ff;
    logic phase_end;
    logic last_second_ff;
    logic dir_ff, count_ff, pend_ff, pend_val_ff;

    // hysteresis comparator on the averaged value
    function automatic logic hyst(input logic signed [`HCD_SENSE_W-1:0] s,
                                  input logic signed [`HCD_SENSE_W-1:0] v,
                                  input logic old,
                                  input logic signed [`HCD_SENSE_W-1:0] ton,
                                  input logic signed [`HCD_SENSE_W-1:0] toff);
        logic signed [`HCD_SENSE_W:0] avg2;
        avg2 = {s[`HCD_SENSE_W-1], s} + {v[`HCD_SENSE_W-1], v};
        if (avg2 > $signed({ton, 1'b0}))
            return 1'b1;
        else if (avg2 < $signed({toff, 1'b0}))
            return 1'b0;
        return old;
    endfunction

    // two-stage synchroniser for the sensed values
    always_ff @(posedge clk_i) begin
        sync1_ff <= sense_i;
        sync2_ff <= sync1_ff;
    end

    // shared two-phase clock, half a period each
    assign phase_end = (cnt_ff == CW'(HALF - 1));
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cnt_ff <= '0;
            phase_ff <= hcd_pkg::HCD_PH_SAMPLE;
        end else if (phase_end) begin
            cnt_ff <= '0;
            phase_ff <= (phase_ff == hcd_pkg::HCD_PH_SAMPLE) ?
                hcd_pkg::HCD_PH_COMPARE : hcd_pkg::HCD_PH_SAMPLE;
        end else begin
            cnt_ff <= cnt_ff + CW'(1);
        end
    end

    // sample both plates at end of first phase
    always_ff @(posedge clk_i) begin
        if (srst_i)
            held_ff <= '0;
        else if (phase_end && phase_ff == hcd_pkg::HCD_PH_SAMPLE)
            held_ff <= sync2_ff;
    end

    // average and compare at end of second phase, once per period
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cmp_ff <= '0;
            prev_ff <= '0;
        end else if (phase_end && phase_ff == hcd_pkg::HCD_PH_COMPARE) begin
            prev_ff <= cmp_ff;
            cmp_ff.first_sense_plate <= hyst(held_ff.first_sense_plate,
                sync2_ff.first_sense_plate, cmp_ff.first_sense_plate, th_on_i, th_off_i);
            cmp_ff.second_sense_plate <= hyst(held_ff.second_sense_plate,
                sync2_ff.second_sense_plate, cmp_ff.second_sense_plate, th_on_i, th_off_i);
        end
    end

    // edge detection one cycle after the compare, at start of sample phase
    logic eval_ff;
    always_ff @(posedge clk_i) begin
        if (srst_i)
            eval_ff <= 1'b0;
        else
            eval_ff <= phase_end && phase_ff == hcd_pkg::HCD_PH_COMPARE;
    end

    logic e1, e2;
    assign e1 = eval_ff && (cmp_ff.first_sense_plate != prev_ff.first_sense_plate);
    assign e2 = eval_ff && (cmp_ff.second_sense_plate != prev_ff.second_sense_plate);

    // remember which comparator switched most recently
    always_ff @(posedge clk_i) begin
        if (srst_i)
            last_second_ff <= 1'b0;
        else if (e1 && !e2)
            last_second_ff <= 1'b0;
        else if (e2 && !e1)
            last_second_ff <= 1'b1;
    end

    // direction on first edge, held otherwise and on coincident edges
    // second switched last means the second led this edge of the first
    always_ff @(posedge clk_i) begin
        if (srst_i)
            dir_ff <= `HCD_DIR_RST;
        else if (e1 && !e2)
            dir_ff <= last_second_ff ^ DIR_HIGH_FIRST_LEADS;
    end

    // count follows the first comparator, released at the next compare phase end
    // direction moved at the start of the sample phase, so setup is above half a period
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pend_ff <= 1'b0;
            pend_val_ff <= 1'b0;
            count_ff <= `HCD_COUNT_RST;
        end else if (e1) begin
            pend_ff <= 1'b1;
            pend_val_ff <= cmp_ff.first_sense_plate;
        end else if (pend_ff && phase_end && phase_ff == hcd_pkg::HCD_PH_COMPARE) begin
            pend_ff <= 1'b0;
            count_ff <= pend_val_ff;
        end
    end

    // open-drain drive: enable pulls low when level is low
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            count_o <= 1'b0;
            count_oe_o <= 1'b1;
            dir_o <= 1'b0;
            dir_oe_o <= 1'b1;
        end else begin
            count_o <= 1'b0;
            count_oe_o <= !count_ff;
            dir_o <= 1'b0;
            dir_oe_o <= !dir_ff;
        end
    end

    // checks
    property p_dir_hold;
        @(posedge clk_i) disable iff (srst_i)
        !(e1 && !e2) |=> $stable(dir_ff);
    endproperty
    a_dir_hold: assert property (p_dir_hold) else $error("direction moved without edge");

    property p_coincident;
        @(posedge clk_i) disable iff (srst_i)
        (e1 && e2) |=> $stable(dir_ff);
    endproperty
    a_coincident: assert property (p_coincident) else $error("coincident edges moved direction");

    property p_count_follow;
        @(posedge clk_i) disable iff (srst_i)
        $changed(count_ff) |-> count_ff == pend_val_ff;
    endproperty
    a_count_follow: assert property (p_count_follow) else $error("count not from comparator");

    property p_setup;
        @(posedge clk_i) disable iff (srst_i)
        $changed(count_ff) |-> $stable(dir_ff) && !pend_ff;
    endproperty
    a_setup: assert property (p_setup) else $error("direction not settled before count");

    property p_dir_value;
        @(posedge clk_i) disable iff (srst_i)
        (e1 && !e2) |=> dir_ff == ($past(last_second_ff) ^ DIR_HIGH_FIRST_LEADS);
    endproperty
    a_dir_value: assert property (p_dir_value) else $error("wrong direction polarity");

    property p_count_only_phase;
        @(posedge clk_i) disable iff (srst_i)
        $changed(count_ff) |-> $past(phase_end) && !$past(e1);
    endproperty
    a_count_only_phase: assert property (p_count_only_phase) else $error("count off phase");

    property p_cmp_period;
        @(posedge clk_i) disable iff (srst_i)
        $changed(cmp_ff) |-> $past(phase_ff) == hcd_pkg::HCD_PH_COMPARE && $past(phase_end);
    endproperty
    a_cmp_period: assert property (p_cmp_period) else $error("compare off period");

    property p_pin;
        @(posedge clk_i) disable iff (srst_i)
        1'b1 |=> dir_oe_o == !$past(dir_ff) && count_oe_o == !$past(count_ff);
    endproperty
    a_pin: assert property (p_pin) else $error("pin drive mismatch");

    // cycles since the direction register was last loaded, saturating
    logic [CW-1:0] dir_age_ff;
    always_ff @(posedge clk_i) begin
        if (srst_i)
            dir_age_ff <= '0;
        else if (e1 && !e2)
            dir_age_ff <= '0;
        else if (dir_age_ff != CW'(OSC_CYCLES))
            dir_age_ff <= dir_age_ff + CW'(1);
    end

    property p_dir_setup;
        @(posedge clk_i) disable iff (srst_i)
        $changed(count_ff) |-> dir_age_ff >= CW'(HALF);
    endproperty
    a_dir_setup: assert property (p_dir_setup) else $error("count edge too close");
endmodule

/* design/hcd_map.svh */
// constants for the hall count and direction detector
// assumes a 200 MHz system clock and two samples, averaged, per internal oscillator period
`ifndef HCD_MAP_SVH
`define HCD_MAP_SVH
// internal oscillator period, ns (150 kHz typical)
`define HCD_OSC_PERIOD_NS 6667
`define HCD_CLK_PERIOD_NS 5
// cycles per oscillator period, rounded down
`define HCD_OSC_CYCLES (`HCD_OSC_PERIOD_NS / `HCD_CLK_PERIOD_NS)
// sensed value width and default thresholds
`define HCD_SENSE_W 12
`define HCD_TH_ON_RST 12'h100
`define HCD_TH_OFF_RST 12'hF00
// reset values of the outputs
`define HCD_COUNT_RST 1'b0
`define HCD_DIR_RST 1'b0
`endif

/* design/hcd_pkg.sv */
// types for the hall count and direction detector
// assumes hcd_map.svh supplies widths
`include "hcd_map.svh"
package hcd_pkg;
    // oscillator phase
    typedef enum logic [1:0] {
        HCD_PH_SAMPLE,
        HCD_PH_COMPARE
    } hcd_phase_e;
    // one signed sensed value per plate
    typedef struct packed {
        logic signed [`HCD_SENSE_W-1:0] first_sense_plate;
        logic signed [`HCD_SENSE_W-1:0] second_sense_plate;
    } hcd_sense_s;
    // comparator states of both plates
    typedef struct packed {
        logic first_sense_plate;
        logic second_sense_plate;
    } hcd_cmp_s;
endpackage

/* verification/hcd_ctrl_model.sv */
// controller model reading the two open-drain pins through pull-ups
// assumes one clock; an enable high pulls its pin low
module hcd_ctrl_model (
    // clock
    input wire logic clk_i,
    // pull-down enables from the detector
    input wire logic count_oe_i,
    input wire logic dir_oe_i,
    // pin levels and the last measured setup time
    output logic count_pin_o,
    output logic dir_pin_o,
    output logic [15:0] setup_o = 16'hFFFF
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] since_ff = 16'hFFFF;
    logic count_ff = 1'b0;
    logic dir_ff = 1'b0;
    // pull-ups lift a released pin
    assign count_pin_o = ~count_oe_i;
    assign dir_pin_o = ~dir_oe_i;
    // cycles from a direction change to the next count edge
    always @(posedge clk_i) begin
        count_ff <= count_pin_o;
        dir_ff <= dir_pin_o;
        if (dir_pin_o !== dir_ff) begin
            since_ff <= 16'h0001;
        end else if (since_ff != 16'hFFFF) begin
            since_ff <= since_ff + 16'h0001;
        end
        if (count_pin_o !== count_ff) begin
            setup_o <= since_ff;
        end
    end
endmodule

/* verification/testbench.sv */
// self-checking bench: two polarity variants side by side, one pin model
// assumes the detector runs with a short oscillator period of 8 cycles
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int OSC = 8;
    localparam logic [11:0] HI = 12'h400;
    localparam logic [11:0] LO = 12'hC00;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    hcd_pkg::hcd_sense_s sense = '0;
    logic signed [11:0] th_on = 12'h100;
    logic signed [11:0] th_off = 12'hF00;
    logic c_oe, d_oe, d_oe_b, c_pin, d_pin, c_lvl, d_lvl;
    logic [15:0] setup;
    int fails = 0;
    int compares = 0;
    // clock and reset
    always #2.5 clk_i = ~clk_i;
    initial begin
        repeat (4) @(posedge clk_i);
        srst_i <= 1'b0;
    end
    hcd_detector #(.OSC_CYCLES(OSC), .DIR_HIGH_FIRST_LEADS(1'b1)) hcd_detector_inst (
        .clk_i(clk_i), .srst_i(srst_i), .sense_i(sense), .th_on_i(th_on),
        .th_off_i(th_off), .count_o(c_lvl), .count_oe_o(c_oe), .dir_o(d_lvl), .dir_oe_o(d_oe));
    // other polarity variant on the same inputs
    hcd_detector #(.OSC_CYCLES(OSC), .DIR_HIGH_FIRST_LEADS(1'b0)) hcd_detector_inst_b (
        .clk_i(clk_i), .srst_i(srst_i), .sense_i(sense), .th_on_i(th_on),
        .th_off_i(th_off), .count_o(), .count_oe_o(), .dir_o(), .dir_oe_o(d_oe_b));
    hcd_ctrl_model hcd_ctrl_model_inst (.clk_i(clk_i), .count_oe_i(c_oe), .dir_oe_i(d_oe),
        .count_pin_o(c_pin), .dir_pin_o(d_pin), .setup_o(setup));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask
    // new plate values, then several oscillator periods to settle
    task automatic drive(input logic [11:0] a, input logic [11:0] b);
        @(posedge clk_i);
        sense <= '{a, b};
        repeat (4 * OSC) @(posedge clk_i);
        #1;
    endtask
    // count pin, direction pin, and the inverted variant
    task automatic chk(input logic c, input logic d);
        check({15'h0, c_pin}, {15'h0, c});
        check({15'h0, d_pin}, {15'h0, d});
        check({15'h0, ~d_oe_b}, {15'h0, ~d});
        check({14'h0, c_lvl, d_lvl}, 16'h0000);
    endtask
    task automatic t_reset;
        repeat (6) @(posedge clk_i);
        #1;
        check({14'h0, c_pin, d_pin}, 16'h0000);
    endtask
    // second plate switches first, then the first plate
    task automatic t_second_leads;
        drive(LO, HI);
        drive(HI, HI);
        chk(1'b1, 1'b0);
        check({15'h0, setup >= OSC / 2}, 16'h0001);
    endtask
    // values on the thresholds exactly hold the comparators
    task automatic t_hold;
        drive(12'hF00, LO);
        chk(1'b1, 1'b0);
        drive(LO, LO);
        chk(1'b0, 1'b0);
        drive(12'h100, LO);
        check({15'h0, c_pin}, 16'h0000);
    endtask
    // first plate switches again with no second edge between
    task automatic t_first_leads;
        drive(12'h101, LO);
        chk(1'b1, 1'b1);
        check({15'h0, setup >= OSC / 2}, 16'h0001);
    endtask
    // second then first set direction low, then both plates switch in one period
    task automatic t_same;
        drive(12'h101, HI);
        chk(1'b1, 1'b1);
        drive(LO, HI);
        chk(1'b0, 1'b0);
        check({15'h0, setup >= OSC / 2}, 16'h0001);
        drive(HI, LO);
        chk(1'b1, 1'b0);
    endtask
    task automatic print_verdict;
        $display("compares %0d fails %0d", compares, fails);
        if (compares > 0 && fails == 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // main sequence
    initial begin
        t_reset();
        t_second_leads();
        t_hold();
        t_first_leads();
        t_same();
        print_verdict();
    end
    // watchdog
    initial begin
        #20000;
        fails++;
        print_verdict();
    end
endmodule
